// *** logic/aie_exec.sv ***
// Execution datapath for memory/port and accumulator instruction groups.
// Assumes the caller presents an opcode with exec_en for one cycle and
// presents the selected chip's nibble on mem_rdata in that same cycle;
// chip/register/character selection lives outside, set by the last
// select_chip_instruction.
//
// Overview of operation
// - Memory and port ops act on the target of the last select.
// - Main or status character reads load the accumulator; carry kept.
// - ROM port read copies input lines; output pins return a fixed value.
// - Main character write stores accumulator; accumulator and carry kept.
// - Status character writes store accumulator into status 0 to 3.
// - ROM port write sends accumulator; port holds it until next write.
// - RAM port write sends accumulator; port holds until next write.
// - Add memory, accumulator and carry; sum and carry out stored.
// - Subtract adds inverted memory and inverted carry to accumulator.
// - Clear both, clear carry, set carry.
// - Complement carry, accumulator unchanged.
// - Complement accumulator, carry unchanged.
// - Increment accumulator, carry shows overflow.
// - Decrement by adding 1111, carry clear on borrow.
// - Rotate carry and accumulator left or right as five bits.
// - Accumulator gets old carry in bit 0, carry cleared.
// - Decimal adjust adds 6 if carry or above 9; carry only sets.
// - Load 9 or 10 by carry, then clear carry.
// - One-hot to binary; more than one bit set gives 15.
// - Bank register takes accumulator bits 0 to 2 and holds.
// - Bank code decodes to RAM bank select lines.
// - Reset selects bank zero.
`timescale 1ns/1ns
`include "aie_regs.svh"
module aie_exec #(
  parameter int DATA_W = 4
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  exec_en,
  input  wire logic [7:0]            opcode,
  input  wire logic [DATA_W-1:0]     mem_rdata,
  output aie_pkg::aie_bus_req_t      bus_req,
  output logic      [DATA_W-1:0]     accumulator,
  output logic                       carry_link,
  output logic      [3:0]            ram_bank_select_line,
  output logic                       illegal_op
);

  ////////////////////////////////////////////////////////////////////////
  // Arithmetic helpers

  // Four-bit add with carry in, shared by add, subtract and step ops
  function automatic aie_pkg::aie_alu_t add4(
    input logic [3:0] a,
    input logic [3:0] b,
    input logic       cin
  );
    logic [4:0] sum;
    sum = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    add4.accumulator = sum[3:0];
    add4.carry_link  = sum[4];
  endfunction

  // One-hot keypad code to binary, zero stays zero, anything else flags an error
  function automatic logic [3:0] kbp_map(input logic [3:0] a);
    case (a)
      4'h0:    kbp_map = 4'h0;
      4'h1:    kbp_map = 4'h1;
      4'h2:    kbp_map = 4'h2;
      4'h4:    kbp_map = 4'h3;
      4'h8:    kbp_map = 4'h4;
      default: kbp_map = `AIE_KBP_ERR;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // State

  aie_pkg::aie_state_t state_ff;
  aie_pkg::aie_state_t nxt_state;
  aie_pkg::aie_alu_t   res;
  logic                bad_op;

  // Next state for one executed instruction
  always_comb begin
    nxt_state = state_ff;
    nxt_state.req = '0; // Write strobes last one cycle
    nxt_state.req.data = state_ff.accumulator;
    res = '{accumulator: state_ff.accumulator,
            carry_link:  state_ff.carry_link};
    bad_op = 1'b0;
    if (exec_en && opcode[7:4] == `AIE_GRP_MEM) begin
      // Target chip came from the last select; we only steer the nibble
      case (aie_pkg::aie_mem_op_t'(opcode[3:0]))
        aie_pkg::AIE_WRM: nxt_state.req.ram_main_wr = 1'b1;
        aie_pkg::AIE_WMP: nxt_state.req.ram_port_wr = 1'b1;
        aie_pkg::AIE_WRR: nxt_state.req.rom_port_wr = 1'b1;
        aie_pkg::AIE_WR0, aie_pkg::AIE_WR1,
        aie_pkg::AIE_WR2, aie_pkg::AIE_WR3: begin
          nxt_state.req.ram_status_wr = 1'b1;
          nxt_state.req.status_idx    = opcode[1:0];
        end
        aie_pkg::AIE_RDM, aie_pkg::AIE_RS0, aie_pkg::AIE_RS1,
        aie_pkg::AIE_RS2, aie_pkg::AIE_RS3:
          res.accumulator = mem_rdata;
        // Output pins already read back the user's fixed level
        aie_pkg::AIE_RDR: res.accumulator = mem_rdata;
        aie_pkg::AIE_ADM:
          res = add4(state_ff.accumulator, mem_rdata,
                     state_ff.carry_link);
        aie_pkg::AIE_SBM:
          res = add4(state_ff.accumulator, ~mem_rdata,
                     ~state_ff.carry_link);
        default: bad_op = 1'b1; // Low nibble 0011 is unassigned
      endcase
    end else if (exec_en && opcode[7:4] == `AIE_GRP_ACC) begin
      case (aie_pkg::aie_acc_op_t'(opcode[3:0]))
        aie_pkg::AIE_CLB: res = '{accumulator: 4'h0,
                                  carry_link:  1'b0};
        aie_pkg::AIE_CLC: res.carry_link = 1'b0;
        aie_pkg::AIE_STC: res.carry_link = 1'b1;
        aie_pkg::AIE_CMC: res.carry_link = ~state_ff.carry_link;
        aie_pkg::AIE_CMA: res.accumulator = ~state_ff.accumulator;
        aie_pkg::AIE_IAC:
          res = add4(state_ff.accumulator, 4'h0, 1'b1);
        // Carry out of adding 1111 is set exactly when no borrow
        aie_pkg::AIE_DAC:
          res = add4(state_ff.accumulator, 4'hF, 1'b0);
        aie_pkg::AIE_RAL: res = '{
          accumulator: {state_ff.accumulator[2:0], state_ff.carry_link},
          carry_link:  state_ff.accumulator[3]};
        aie_pkg::AIE_RAR: res = '{
          accumulator: {state_ff.carry_link, state_ff.accumulator[3:1]},
          carry_link:  state_ff.accumulator[0]};
        aie_pkg::AIE_TCC: res = '{
          accumulator: {3'h0, state_ff.carry_link},
          carry_link:  1'b0};
        aie_pkg::AIE_DAA: begin
          if (state_ff.carry_link ||
              state_ff.accumulator > `AIE_DAA_LIMIT) begin
            res = add4(state_ff.accumulator, `AIE_DAA_ADD, 1'b0);
            // Carry may only be set here, never cleared
            res.carry_link = res.carry_link | state_ff.carry_link;
          end
        end
        aie_pkg::AIE_TCS: res = '{
          accumulator: state_ff.carry_link ? `AIE_TCS_SET : `AIE_TCS_CLR,
          carry_link:  1'b0};
        aie_pkg::AIE_KBP:
          res.accumulator = kbp_map(state_ff.accumulator);
        aie_pkg::AIE_DCL:
          nxt_state.bank = state_ff.accumulator[2:0];
        default: bad_op = 1'b1;
      endcase
    end
    nxt_state.accumulator = res.accumulator;
    nxt_state.carry_link  = res.carry_link;
  end

  // Register the state; reset picks bank zero until a bank op runs
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_ff <= '{accumulator: `AIE_ACC_RST,
                    carry_link:  `AIE_CARRY_RST,
                    bank:        `AIE_BANK_RST,
                    req:         '0};
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Flag unassigned opcodes registered for a clean output
  logic illegal_ff;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      illegal_ff <= 1'b0;
    end else begin
      illegal_ff <= bad_op;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  // Port latches in the chips hold the value until their next write
  assign bus_req     = state_ff.req;
  assign accumulator = state_ff.accumulator;
  assign carry_link  = state_ff.carry_link;
  assign illegal_op  = illegal_ff;

  // Bank lines follow the held bank register
  aie_bank_decode u_bank (
    .bank                 (state_ff.bank),
    .ram_bank_select_line (ram_bank_select_line)
  );

endmodule

// *** logic/aie_regs.svh ***
// Constants for the accumulator and port execution block.
// Assumes inclusion by the package and the datapath; definitions only.
`ifndef AIE_REGS_SVH
`define AIE_REGS_SVH
`define AIE_GRP_MEM       4'hE
`define AIE_GRP_ACC       4'hF
`define AIE_ACC_RST       4'h0
`define AIE_CARRY_RST     1'b0
`define AIE_BANK_RST      3'h0
`define AIE_DAA_LIMIT     4'h9
`define AIE_DAA_ADD       4'h6
`define AIE_TCS_CLR       4'h9
`define AIE_TCS_SET       4'hA
`define AIE_KBP_ERR       4'hF
`define AIE_STATUS_W      2
`endif

// *** logic/aie_pkg.sv ***
// Types for the accumulator and port execution block.
// Assumes the constants header sits beside this file.
`include "aie_regs.svh"
package aie_pkg;
  // Memory/port group low nibbles
  typedef enum logic [3:0] {
    AIE_WRM = 4'h0, AIE_WMP = 4'h1, AIE_WRR = 4'h2,
    AIE_WR0 = 4'h4, AIE_WR1 = 4'h5, AIE_WR2 = 4'h6, AIE_WR3 = 4'h7,
    AIE_SBM = 4'h8, AIE_RDM = 4'h9, AIE_RDR = 4'hA, AIE_ADM = 4'hB,
    AIE_RS0 = 4'hC, AIE_RS1 = 4'hD, AIE_RS2 = 4'hE, AIE_RS3 = 4'hF
  } aie_mem_op_t;
  // Accumulator group low nibbles
  typedef enum logic [3:0] {
    AIE_CLB = 4'h0, AIE_CLC = 4'h1, AIE_IAC = 4'h2, AIE_CMC = 4'h3,
    AIE_CMA = 4'h4, AIE_RAL = 4'h5, AIE_RAR = 4'h6, AIE_TCC = 4'h7,
    AIE_DAC = 4'h8, AIE_TCS = 4'h9, AIE_STC = 4'hA, AIE_DAA = 4'hB,
    AIE_KBP = 4'hC, AIE_DCL = 4'hD, AIE_NA1 = 4'hE, AIE_NA2 = 4'hF
  } aie_acc_op_t;
  // Bus request toward the selected memory or port chip
  typedef struct packed {
    logic       ram_main_wr;
    logic       ram_status_wr;
    logic       rom_port_wr;
    logic       ram_port_wr;
    logic [1:0] status_idx;
    logic [3:0] data;
  } aie_bus_req_t;
  // Result of one instruction
  typedef struct packed {
    logic [3:0] accumulator;
    logic       carry_link;
  } aie_alu_t;
  // Register state of the datapath except the illegal-op flag
  typedef struct packed {
    logic [3:0]   accumulator;
    logic         carry_link;
    logic [2:0]   bank;
    aie_bus_req_t req;
  } aie_state_t;
endpackage

// *** logic/aie_bank_decode.sv ***
// Bank register to RAM bank select line decoder.
// Assumes a 3-bit bank code from the execution datapath.
`timescale 1ns/1ns
`include "aie_regs.svh"
module aie_bank_decode (
  input  wire logic [2:0] bank,
  output logic      [3:0] ram_bank_select_line
);
  // Bank 0 uses line 0 alone; others are the code spread on lines 1..3
  always_comb begin
    if (bank == `AIE_BANK_RST) begin
      ram_bank_select_line = 4'h1;
    end else begin
      ram_bank_select_line = {bank, 1'b0};
    end
  end
endmodule

// *** test/aie_chip_model.sv ***
// Behavioural RAM/ROM chip on the far side of the execution block.
// Assumes one selected chip and strobes registered by the datapath.
`timescale 1ns/1ns
module aie_chip_model #(
  parameter logic [3:0] OUT_MASK = 4'h0,
  parameter logic       FILL     = 1'b0
) (
  input  wire logic                  clk,
  input  wire logic                  exec_en,
  input  wire logic [7:0]            opcode,
  input  wire logic [3:0]            rom_in,
  input  wire aie_pkg::aie_bus_req_t bus_req,
  output logic      [3:0]            mem_rdata,
  output logic      [3:0]            rom_q,
  output logic      [3:0]            ram_q
);
  logic [3:0] main_ff;
  logic [3:0] stat_ff [0:3];
  logic [3:0] val;
  ////////////////
  // One nibble per op; output pins read as the fill level
  always_comb begin
    case (opcode[3:0])
      4'hA:    val = (rom_in & ~OUT_MASK) | ({4{FILL}} & OUT_MASK);
      4'hC, 4'hD, 4'hE, 4'hF: val = stat_ff[opcode[1:0]];
      default: val = main_ff;
    endcase
    // Not driven outside a transfer, so show no stale value
    mem_rdata = exec_en ? val : ~val;
  end
  // Ports hold until the next write to the same chip
  always_ff @(posedge clk) begin
    if (bus_req.ram_main_wr) main_ff <= bus_req.data;
    if (bus_req.ram_status_wr) stat_ff[bus_req.status_idx] <= bus_req.data;
    if (bus_req.rom_port_wr) rom_q <= bus_req.data & ~OUT_MASK;
    if (bus_req.ram_port_wr) ram_q <= bus_req.data;
  end
endmodule

// *** test/aie_exec_checker.sv ***
// Concurrent checks on the execution block's ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ns
module aie_exec_checker (
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  exec_en,
  input wire logic [7:0]            opcode,
  input wire logic [3:0]            mem_rdata,
  input wire aie_pkg::aie_bus_req_t bus_req,
  input wire logic [3:0]            accumulator,
  input wire logic                  carry_link,
  input wire logic [3:0]            ram_bank_select_line,
  input wire logic                  illegal_op
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  ////////////////
  main_wr_a: assert property (exec_en && opcode == 8'hE0 |=>
    bus_req.ram_main_wr && bus_req.data == $past(accumulator))
    else $error("main write strobe wrong");
  stat_wr_a: assert property (exec_en && opcode[7:2] == 6'h39 |=>
    bus_req.ram_status_wr && bus_req.status_idx == $past(opcode[1:0]))
    else $error("status write strobe wrong");
  rom_wr_a: assert property (exec_en && opcode == 8'hE2 |=>
    bus_req.rom_port_wr && bus_req.data == $past(accumulator))
    else $error("rom port strobe wrong");
  ram_wr_a: assert property (exec_en && opcode == 8'hE1 |=>
    bus_req.ram_port_wr && $stable(accumulator))
    else $error("ram port strobe wrong");
  read_main_a: assert property (exec_en && opcode == 8'hE9 |=>
    accumulator == $past(mem_rdata) && $stable(carry_link))
    else $error("main read wrong");
  inc_acc_a: assert property (exec_en && opcode == 8'hF2 |=>
    {carry_link, accumulator} == {1'b0, $past(accumulator)} + 5'h01)
    else $error("increment wrong");
  inv_carry_a: assert property (exec_en && opcode == 8'hF3 |=>
    carry_link != $past(carry_link) && $stable(accumulator))
    else $error("carry invert wrong");
  bank_hold_a: assert property (!(exec_en && opcode == 8'hFD) |=>
    $stable(ram_bank_select_line))
    else $error("bank lines moved");
  bank_rst_a: assert property (disable iff (1'b0) !reset_n |=>
    ram_bank_select_line == 4'h1)
    else $error("bank lines after reset wrong");
  // Main scenarios reached
  c_add_c: cover property (exec_en && opcode == 8'hEB);
  c_dcl_c: cover property (exec_en && opcode == 8'hFD);
  c_ill_c: cover property (illegal_op);
endmodule
bind aie_exec aie_exec_checker u_chk (.*);

// *** test/tb_accumulator_and_io_instruction_exec.sv ***
// Self-checking bench for the execution block with a chip model.
// Assumes the design package and the chip model are compiled first.
`timescale 1ns/1ns
module tb_accumulator_and_io_instruction_exec;
  logic clk = 0, reset_n = 0, exec_en = 0, cy, ill;
  logic [7:0] opcode = 8'h00;
  logic [3:0] rdata, rom_in = 4'h0, acc, rom_q, ram_q, lines;
  aie_pkg::aie_bus_req_t bus_req;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  // Rows: rom input, opcode, expected accumulator, expected carry
  logic [19:0] rows [0:33] = '{20'hA_EAA0, 20'h0_E0A0, 20'h0_FAA1,
    20'h0_EB51, 20'h0_E8A0, 20'h0_F3A1, 20'h0_F451, 20'h0_F5B0,
    20'h0_F651, 20'h0_F710, 20'h0_F220, 20'h0_F811, 20'h0_F9A0,
    20'h0_FB01, 20'h0_F100, 20'h0_F8F0, 20'h0_F201, 20'h0_F9A0,
    20'h0_F990, 20'h0_FB90, 20'h8_EA80, 20'h0_FC40, 20'h6_EA60,
    20'h0_FCF0, 20'h4_EA40, 20'h0_FC30, 20'h3_EA30, 20'h0_E530,
    20'h0_E9A0, 20'h0_ED30, 20'h0_F000, 20'h0_FC00, 20'h0_FA01,
    20'h0_FB61};
  logic [3:0] bank_exp [0:7] = '{4'h1, 4'h2, 4'h4, 4'h6,
                                 4'h8, 4'hA, 4'hC, 4'hE};
  aie_exec dut (.clk(clk), .reset_n(reset_n), .exec_en(exec_en),
    .opcode(opcode), .mem_rdata(rdata), .bus_req(bus_req),
    .accumulator(acc), .carry_link(cy),
    .ram_bank_select_line(lines), .illegal_op(ill));
  aie_chip_model u_chip (.clk(clk), .exec_en(exec_en), .opcode(opcode),
    .rom_in(rom_in), .bus_req(bus_req), .mem_rdata(rdata),
    .rom_q(rom_q), .ram_q(ram_q));
  ////////////////
  initial forever #4 clk = ~clk;
  // Hang guard well beyond the planned 138 or so cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(string nm, logic [3:0] e, logic [3:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One instruction; results are settled on return
  task automatic run(logic [3:0] r, logic [7:0] op);
    @(posedge clk); #1;
    rom_in = r; exec_en = 1; opcode = op;
    @(posedge clk); #1;
    exec_en = 0;
  endtask
  task automatic complete_run();
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////
  initial begin
    repeat (20) @(posedge clk);
    #1 reset_n = 1;
    chk("rst acc", 4'h0, acc);
    chk("rst lines", 4'h1, lines);
    $display("test reset done");
    foreach (rows[i]) begin
      run(rows[i][19:16], rows[i][15:8]);
      chk("acc", rows[i][7:4], acc);
      chk("carry", {3'h0, rows[i][0]}, {3'h0, cy});
    end
    $display("test table done");
    for (int v = 0; v < 8; v++) begin
      run(4'(v + 8), 8'hEA);
      run(4'h0, 8'hFD);
      chk("lines", bank_exp[v], lines);
    end
    run(4'h5, 8'hEA);
    chk("lines held", 4'hE, lines);
    run(4'h0, 8'hE2);
    chk("rom strobe", 4'h5, {3'h0, bus_req.rom_port_wr} * bus_req.data);
    run(4'h9, 8'hEA);
    run(4'h0, 8'hE1);
    @(posedge clk); #1;
    chk("ram port", 4'h9, ram_q);
    chk("rom port", 4'h5, rom_q);
    run(4'h0, 8'hE3);
    chk("illegal", 4'h1, {3'h0, ill});
    chk("illegal acc", 4'h9, acc);
    run(4'h3, 8'h2A);
    chk("ignored", 4'h9, acc);
    chk("ignored flag", 4'h0, {3'h0, ill});
    // Back to back writes, no idle cycle between
    @(posedge clk); #1;
    exec_en = 1; opcode = 8'hE0;
    @(posedge clk); #1;
    opcode = 8'hE7;
    chk("b2b main", 4'h1, {3'h0, bus_req.ram_main_wr});
    @(posedge clk); #1;
    exec_en = 0;
    chk("b2b idx", 4'hB, {bus_req.ram_status_wr, 1'b0, bus_req.status_idx});
    $display("test ports done");
    reset_n = 0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1;
    chk("rerst lines", 4'h1, lines);
    chk("rerst acc", 4'h0, acc);
    $display("test mid reset done");
    complete_run();
  end
endmodule
